// File: dv/pfs_cmp_model.sv
/*
 Model of the comparators and power stage facing the fault supervisor.
 Assumes the bench sets every comparator level in req; the switching
 clock runs free at one quarter of hclk.
*/
`timescale 1ns/1ps
module pfs_cmp_model (
	input wire logic hclk,
	input wire pfs_pkg::pfs_cmp_t req,
	output pfs_pkg::pfs_cmp_t cmp
);
	logic [1:0] div = 2'h0;

	always_ff @(posedge hclk) begin
		div <= div + 2'h1;
	end

	always_comb begin
		cmp = req;
		cmp.sw_clk = div[1];
	end
endmodule

// File: dv/pfs_supervisor_tb_top.sv
/*
 Self-checking bench of the power fault supervisor.
 Assumes the comparator model beside it and a shortened delay count.
*/
`timescale 1ns/1ps
module pfs_supervisor_tb_top;
	localparam int DLY = 20;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [22:0] c;
	logic [22:0] rows [3] = '{23'h000000, 23'h023FC1, 23'h00ED40};
	pfs_pkg::pfs_cmp_t req = '0;
	pfs_pkg::pfs_cmp_t cmp;
	pfs_pkg::pfs_drv_t drv;
	int failures = 0;
	int tests_run = 0;

	pfs_supervisor #(.DLY_CYC(DLY)) uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp(cmp), .drv(drv));
	pfs_cmp_model model (.hclk(hclk), .req(req), .cmp(cmp));

	always #10 hclk = ~hclk;

	task final_report();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task check(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Lets delayed conditions settle, then pulses the group enable pin low
	task grp_clr();
		cyc(12);
		req.grp_en <= 1'b0;
		cyc(5);
		req.grp_en <= 1'b1;
		cyc(5);
	endtask

	// Bounded wait for hready at a rising edge
	task wrdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 16);
		if (hreadyout !== 1'b1) begin
			failures++;
			final_report();
		end
	endtask

	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		wrdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wrdy();
		r = hrdata;
	endtask

	function automatic logic [15:0] ol(input logic boost, input logic [3:0] k);
		if (boost) begin
			return pfs_pkg::BOOST_BASE_MV + 16'(k) * pfs_pkg::BOOST_STEP_MV - pfs_pkg::BOOST_OL_OFS_MV;
		end
		return pfs_pkg::FB_BASE_MV + 16'(k) * pfs_pkg::FB_STEP_MV - pfs_pkg::FB_OL_OFS_MV;
	endfunction

	initial begin
		req.grp_en = 1'b1;
		cyc(20);
		hresetn <= 1'b1;
		cyc(5);
		check("drv_rst", 32'h0, drv.unit_sd);
		ahb(1'b0, 32'(pfs_pkg::STAT_OFS), 32'h0, rd);
		check("stat_rst", 32'h0, rd);
		ahb(1'b0, 32'h00000010, 32'h0, rd);
		check("unmapped", 32'h0, rd);
		for (int i = 0; i < 3; i++) begin
			c = rows[i];
			ahb(1'b1, 32'(pfs_pkg::CTRL_OFS), {9'h0, c}, rd);
			ahb(1'b0, 32'(pfs_pkg::CTRL_OFS), 32'h0, rd);
			check("ctrl", {9'h0, c}, rd);
			cyc(3);
			check("boost_ol", ol(1'b1, c[9:6]), drv.boost_ol_mv);
			check("bb_ol", ol(1'b0, {1'b0, c[12:10]}), drv.bb_ol_mv);
			check("bucka_ol", ol(1'b0, {1'b0, c[15:13]}), drv.bucka_ol_mv);
			check("buckb_ol", ol(1'b0, {1'b0, c[18:16]}), drv.buckb_ol_mv);
			check("bl_ovp", c[0] ? pfs_pkg::BL_OVP_HI_MV : pfs_pkg::BL_OVP_LO_MV, drv.bl_ovp_mv);
		end
		req.hot <= 1'b1;
		cyc(5);
		req.hot <= 1'b0;
		cyc(5);
		check("hot_hold", 32'h3F, drv.sw_off);
		req.cool <= 1'b1;
		cyc(5);
		check("cool", 32'h0, drv.sw_off);
		req.cool <= 1'b0;
		req.ilim[2] <= 1'b1;
		cyc(5);
		check("ilim_off", 32'h1, drv.sw_off[2]);
		req.ilim[2] <= 1'b0;
		cyc(14);
		check("ilim_back", 32'h0, drv.sw_off[2]);
		req.ss_done[1] <= 1'b1;
		req.fb_low[1] <= 1'b1;
		cyc(5);
		req.fb_low[1] <= 1'b0;
		cyc(5);
		check("fb_lat", 32'h1, drv.sw_off[1]);
		req.sys_uv <= 1'b1;
		cyc(5);
		req.sys_uv <= 1'b0;
		cyc(5);
		check("sys_uv", 32'h1, drv.unit_sd);
		req.sys_ok <= 1'b1;
		cyc(5);
		check("sys_ok", 32'h0, drv.unit_sd);
		req.sys_ok <= 1'b0;
		req.isup_ov <= 1'b1;
		cyc(DLY - 5);
		req.isup_ov <= 1'b0;
		cyc(5);
		check("ov_short", 32'h0, drv.unit_sd);
		req.isup_ov <= 1'b1;
		cyc(DLY + 8);
		check("ov_long", 32'h1, drv.unit_sd);
		req.isup_ov <= 1'b0;
		req.isup_low <= 1'b1;
		cyc(6);
		check("ov_rec", 32'h0, drv.unit_sd);
		req.isup_low <= 1'b0;
		req.ldo_ilim[0] <= 1'b1;
		cyc(5);
		check("ldo_off", 32'h1, drv.ldo_off[0]);
		cyc(DLY + 5);
		check("ldo_sd", 32'h1, drv.unit_sd);
		ahb(1'b1, 32'(pfs_pkg::CTRL_OFS), 32'h0000003E, rd);
		req.ldo_ilim[0] <= 1'b0;
		grp_clr();
		check("clr_sd", 32'h0, drv.unit_sd);
		check("clr_sw", 32'h0, drv.sw_off);
		ahb(1'b0, 32'(pfs_pkg::CTRL_OFS), 32'h0, rd);
		check("dim_clr", 32'h0, rd);
		check("hresp", 32'h0, hresp);
		check("hready", 32'h1, hreadyout);
		req.ol[0] <= 1'b1;
		cyc(6);
		req.ol[0] <= 1'b0;
		cyc(14);
		check("ol_short", 32'h0, drv.unit_sd);
		req.ol[0] <= 1'b1;
		cyc(DLY + 12);
		check("ol_long", 32'h1, drv.unit_sd);
		ahb(1'b0, 32'(pfs_pkg::TOUT_OFS), 32'h0, rd);
		check("tout_ol", 32'h40, rd);
		req.ol[0] <= 1'b0;
		grp_clr();
		req.boost_pre_done <= 1'b1;
		req.fb_low[0] <= 1'b1;
		cyc(5);
		req.fb_low[0] <= 1'b0;
		cyc(5);
		check("boost_fb", 32'h1, drv.sw_off[0]);
		ahb(1'b0, 32'(pfs_pkg::STAT_OFS), 32'h0, rd);
		check("stat_fb", 32'h40, rd);
		grp_clr();
		req.ss_done[0] <= 1'b1;
		req.boost_uv1 <= 1'b1;
		cyc(5);
		check("uv1_off", 32'h1, drv.sw_off[0]);
		check("uv1_wait", 32'h0, drv.unit_sd);
		cyc(DLY + 3);
		check("uv1_sd", 32'h1, drv.unit_sd);
		req.boost_uv1 <= 1'b0;
		grp_clr();
		check("uv1_clr", 32'h0, drv.sw_off);
		req.bl_ovp <= 1'b1;
		cyc(5);
		req.bl_ovp <= 1'b0;
		cyc(5);
		check("bl_off", 32'h1, drv.bl_disable);
		check("bl_sw", 32'h20, drv.sw_off);
		hresetn <= 1'b0;
		cyc(3);
		hresetn <= 1'b1;
		cyc(5);
		check("bl_rst", 32'h0, drv.bl_disable);
		ce <= 1'b0;
		req.sys_uv <= 1'b1;
		cyc(6);
		check("ce_frz", 32'h0, drv.unit_sd);
		ce <= 1'b1;
		req.sys_uv <= 1'b0;
		cyc(5);
		check("ce_run", 32'h0, drv.unit_sd);
		final_report();
	end
endmodule

// File: include/pfs_pkg.sv
/*
 Package of the power fault supervisor: register offsets, field layouts,
 comparator and drive bundles, timing counts.
 Assumes a 50 MHz clock and comparator flags that are active high.
*/
package pfs_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int DLY_MS = 100;
	localparam int DLY_CYC = DLY_MS * (CLK_HZ / 1000);
	localparam int NDLY = 15;
	localparam int ISUP_OV_IDX = 14;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] TOUT_OFS = 8'h08;
	localparam logic [22:0] CTRL_RST = 23'h000000;
	localparam logic [15:0] BOOST_BASE_MV = 16'h0C80;
	localparam logic [15:0] BOOST_STEP_MV = 16'h0064;
	localparam logic [15:0] FB_BASE_MV = 16'h0320;
	localparam logic [15:0] FB_STEP_MV = 16'h0064;
	localparam logic [15:0] BOOST_OL_OFS_MV = 16'h0258;
	localparam logic [15:0] FB_OL_OFS_MV = 16'h0064;
	localparam logic [15:0] BL_OVP_LO_MV = 16'h3E80;
	localparam logic [15:0] BL_OVP_HI_MV = 16'h61A8;

	typedef struct packed {
		logic [3:0] buck_c_target_select;
		logic [2:0] buck_b_feedback_select;
		logic [2:0] buck_a_feedback_select;
		logic [2:0] buckboost_feedback_select;
		logic [3:0] boost_target_select;
		logic [4:0] backlight_enable_dim_field;
		logic backlight_ovp_level_select;
	} pfs_ctrl_t;

	// Channel order: boost, buck-boost, buck a, buck b, buck c, backlight
	typedef struct packed {
		logic grp_en;
		logic sw_clk;
		logic sys_uv;
		logic sys_ok;
		logic isup_ov;
		logic isup_low;
		logic isup_uv;
		logic [5:0] ilim;
		logic [4:0] ol;
		logic boost_uv1;
		logic [4:0] fb_low;
		logic [4:0] ss_done;
		logic boost_pre_done;
		logic bl_ovp;
		logic hot;
		logic cool;
		logic [1:0] ldo_ilim;
	} pfs_cmp_t;

	typedef struct packed {
		logic [5:0] sw_off;
		logic [1:0] ldo_off;
		logic unit_sd;
		logic bl_disable;
		logic [15:0] boost_ol_mv;
		logic [15:0] bb_ol_mv;
		logic [15:0] bucka_ol_mv;
		logic [15:0] buckb_ol_mv;
		logic [15:0] bl_ovp_mv;
	} pfs_drv_t;
endpackage

// File: rtl/pfs_supervisor.sv
/*
 Power fault supervisor with an AHB-Lite register slave.
 Assumes asynchronous comparator flags, a switching clock pin and a
 single-slave bus whose hready is this slave's hreadyout.
*/
`timescale 1ns/1ps
module pfs_supervisor #(
	parameter int DLY_CYC = pfs_pkg::DLY_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire pfs_pkg::pfs_cmp_t cmp,
	output pfs_pkg::pfs_drv_t drv
);
	localparam logic [22:0] LIM = 23'(DLY_CYC);

	function automatic logic [15:0] ol_mv(input logic [3:0] code, input logic [15:0] base,
		input logic [15:0] step, input logic [15:0] ofs);
		ol_mv = 16'(base + 16'(code * step) - ofs);
	endfunction

	pfs_pkg::pfs_cmp_t cmp_s1;
	pfs_pkg::pfs_cmp_t s;
	pfs_pkg::pfs_ctrl_t ctrl;
	pfs_pkg::pfs_drv_t next_drv;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic sw_q;
	logic tick;
	logic [4:0] ol_seen;
	logic [4:0] ol_run;
	logic [5:0] ilim_hold;
	logic [pfs_pkg::NDLY-1:0] dly_cond;
	logic [pfs_pkg::NDLY-1:0] expd;
	logic [22:0] cnt [pfs_pkg::NDLY];
	logic [13:0] to_lat;
	logic [4:0] fb_lat;
	logic sys_uv_lat;
	logic isup_uv_lat;
	logic isup_ov_sd;
	logic bl_lat;
	logic therm;
	logic unit_sd;
	logic [31:0] stat;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Two-stage synchroniser for all comparator pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmp_s1 <= '0;
			s <= '0;
		end else if (ce) begin
			cmp_s1 <= cmp;
			s <= cmp_s1;
		end
	end

	// Bus address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (ce && hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= pfs_pkg::CTRL_RST;
		end else if (ce) begin
			if (wr_pend && wr_addr == pfs_pkg::CTRL_OFS) begin
				ctrl <= pfs_pkg::pfs_ctrl_t'(hwdata[22:0]);
			end
			if (!s.grp_en) begin
				ctrl.backlight_enable_dim_field <= 5'h00;
			end
		end
	end

	assign stat = {20'h00000, |to_lat, fb_lat, bl_lat, therm, isup_uv_lat, isup_ov_sd, sys_uv_lat, unit_sd};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ce && hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				pfs_pkg::CTRL_OFS: hrdata <= {9'h000, ctrl};
				pfs_pkg::STAT_OFS: hrdata <= stat;
				pfs_pkg::TOUT_OFS: hrdata <= {17'h00000, expd[pfs_pkg::ISUP_OV_IDX], to_lat};
				default: hrdata <= 32'h00000000;
			endcase
		end
	end

	// Switching cycle tracking
	assign tick = s.sw_clk & ~sw_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_q <= 1'b0;
			ol_seen <= 5'h00;
			ol_run <= 5'h00;
			ilim_hold <= 6'h00;
		end else if (ce) begin
			sw_q <= s.sw_clk;
			ol_seen <= tick ? s.ol : (ol_seen | s.ol);
			if (tick) begin
				ol_run <= ol_seen | s.ol;
			end
			ilim_hold <= (ilim_hold & ~{6{tick}}) | s.ilim;
		end
	end

	assign dly_cond = {s.isup_ov, s.ldo_ilim, s.boost_uv1 & s.ss_done[0], ol_run, s.ilim};

	// Qualification counters, one per delayed fault
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < pfs_pkg::NDLY; i++) begin
				cnt[i] <= 23'h000000;
			end
		end else if (ce) begin
			for (int i = 0; i < pfs_pkg::NDLY; i++) begin
				if (!dly_cond[i]) begin
					cnt[i] <= 23'h000000;
				end else if (cnt[i] != LIM) begin
					cnt[i] <= cnt[i] + 23'h000001;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < pfs_pkg::NDLY; i++) begin
			expd[i] = cnt[i] == LIM;
		end
	end

	// Fault latches; a set in the clearing cycle wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			to_lat <= 14'h0000;
			fb_lat <= 5'h00;
			sys_uv_lat <= 1'b0;
			isup_uv_lat <= 1'b0;
			isup_ov_sd <= 1'b0;
			bl_lat <= 1'b0;
			therm <= 1'b0;
		end else if (ce) begin
			to_lat <= (s.grp_en ? to_lat : 14'h0000) | expd[13:0];
			fb_lat <= (s.grp_en ? fb_lat : 5'h00)
				| {s.fb_low[4:1] & s.ss_done[4:1], s.fb_low[0] & s.boost_pre_done};
			sys_uv_lat <= s.sys_uv | (sys_uv_lat & s.grp_en & ~s.sys_ok);
			isup_uv_lat <= s.isup_uv | (isup_uv_lat & s.grp_en);
			isup_ov_sd <= expd[pfs_pkg::ISUP_OV_IDX] | (isup_ov_sd & ~s.isup_low);
			bl_lat <= s.bl_ovp | (bl_lat & s.grp_en);
			therm <= s.hot | (therm & ~s.cool);
		end
	end

	assign unit_sd = sys_uv_lat | isup_uv_lat | isup_ov_sd | (|to_lat);

	always_comb begin
		next_drv.unit_sd = unit_sd;
		for (int i = 0; i < 5; i++) begin
			next_drv.sw_off[i] = unit_sd | therm | ilim_hold[i] | s.ilim[i] | fb_lat[i];
		end
		next_drv.sw_off[0] = next_drv.sw_off[0] | (s.boost_uv1 & s.ss_done[0]);
		next_drv.sw_off[5] = unit_sd | therm | ilim_hold[5] | s.ilim[5] | bl_lat;
		next_drv.ldo_off = {2{unit_sd}} | s.ldo_ilim;
		next_drv.bl_disable = bl_lat | unit_sd;
		next_drv.boost_ol_mv = ol_mv(ctrl.boost_target_select, pfs_pkg::BOOST_BASE_MV,
			pfs_pkg::BOOST_STEP_MV, pfs_pkg::BOOST_OL_OFS_MV);
		next_drv.bb_ol_mv = ol_mv({1'b0, ctrl.buckboost_feedback_select}, pfs_pkg::FB_BASE_MV,
			pfs_pkg::FB_STEP_MV, pfs_pkg::FB_OL_OFS_MV);
		next_drv.bucka_ol_mv = ol_mv({1'b0, ctrl.buck_a_feedback_select}, pfs_pkg::FB_BASE_MV,
			pfs_pkg::FB_STEP_MV, pfs_pkg::FB_OL_OFS_MV);
		next_drv.buckb_ol_mv = ol_mv({1'b0, ctrl.buck_b_feedback_select}, pfs_pkg::FB_BASE_MV,
			pfs_pkg::FB_STEP_MV, pfs_pkg::FB_OL_OFS_MV);
		next_drv.bl_ovp_mv = ctrl.backlight_ovp_level_select ? pfs_pkg::BL_OVP_HI_MV
			: pfs_pkg::BL_OVP_LO_MV;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			drv <= '0;
		end else if (ce) begin
			drv <= next_drv;
		end
	end

	sequence s_hot;
		ce && s.hot;
	endsequence

	property p_sys_uv;
		@(posedge hclk) disable iff (!hresetn) (ce && s.sys_uv) |=> sys_uv_lat;
	endproperty
	a_sys_uv: assert property (p_sys_uv) else $error("sys uv not latched");

	property p_sys_uv_sd;
		@(posedge hclk) disable iff (!hresetn) (ce && sys_uv_lat) |=> drv.unit_sd;
	endproperty
	a_sys_uv_sd: assert property (p_sys_uv_sd) else $error("no shutdown on sys uv");

	property p_isup_ov;
		@(posedge hclk) disable iff (!hresetn) (ce && expd[pfs_pkg::ISUP_OV_IDX]) |=> isup_ov_sd;
	endproperty
	a_isup_ov: assert property (p_isup_ov) else $error("ov delay expiry ignored");

	property p_hold;
		@(posedge hclk) disable iff (!hresetn) (ce && s.grp_en) |=> (fb_lat & $past(fb_lat)) == $past(fb_lat);
	endproperty
	a_hold: assert property (p_hold) else $error("channel latch lost");

	property p_ilim;
		@(posedge hclk) disable iff (!hresetn) (ce && s.ilim[0]) |=> drv.sw_off[0];
	endproperty
	a_ilim: assert property (p_ilim) else $error("limit did not switch off");

	property p_ol;
		@(posedge hclk) disable iff (!hresetn) (ce && expd[6]) |=> to_lat[6] && unit_sd;
	endproperty
	a_ol: assert property (p_ol) else $error("overload expiry ignored");

	property p_bl;
		@(posedge hclk) disable iff (!hresetn) (ce && bl_lat) |=> drv.bl_disable && drv.sw_off[5];
	endproperty
	a_bl: assert property (p_bl) else $error("backlight not disabled");

	property p_therm;
		@(posedge hclk) disable iff (!hresetn) s_hot |=> therm;
	endproperty
	a_therm: assert property (p_therm) else $error("thermal stop missed");

	property p_cnt;
		@(posedge hclk) disable iff (!hresetn) (ce && !dly_cond[0]) |=> cnt[0] == 23'h000000;
	endproperty
	a_cnt: assert property (p_cnt) else $error("counter not cleared");

	property p_fb_boost;
		@(posedge hclk) disable iff (!hresetn) (ce && s.fb_low[0] && s.boost_pre_done) |=> fb_lat[0];
	endproperty
	a_fb_boost: assert property (p_fb_boost) else $error("boost feedback fault not latched");

	property p_fb_ch;
		@(posedge hclk) disable iff (!hresetn) (ce && s.fb_low[1] && s.ss_done[1]) |=> fb_lat[1];
	endproperty
	a_fb_ch: assert property (p_fb_ch) else $error("channel feedback fault not latched");

	property p_uv1;
		@(posedge hclk) disable iff (!hresetn) (ce && s.boost_uv1 && s.ss_done[0]) |=> drv.sw_off[0];
	endproperty
	a_uv1: assert property (p_uv1) else $error("boost low output not switched off");

	property p_ldo;
		@(posedge hclk) disable iff (!hresetn) (ce && s.ldo_ilim[0]) |=> drv.ldo_off[0];
	endproperty
	a_ldo: assert property (p_ldo) else $error("regulator pass not turned off");

	property p_dim;
		@(posedge hclk) disable iff (!hresetn) (ce && !s.grp_en) |=> ctrl.backlight_enable_dim_field == 5'h00;
	endproperty
	a_dim: assert property (p_dim) else $error("dim field not cleared");

	property p_cool;
		@(posedge hclk) disable iff (!hresetn) (ce && therm && s.cool && !s.hot) |=> !therm;
	endproperty
	a_cool: assert property (p_cool) else $error("thermal stop not released");

	property p_freeze;
		@(posedge hclk) disable iff (!hresetn) !ce |=> $stable(drv);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved with clock enable low");
endmodule
